// file: logic/rsc_top.sv
// Reset source controller: pin, brown-out and watchdog reset sequencing
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "rsc_cfg.svh"

module rsc_top
    import rsc_pkg::*;
#(
    parameter logic [23:0] EXT_DELAY_CYC = 24'(`RSC_EXT_DELAY_CYC),
    parameter logic [23:0] LVR_DELAY_CYC = 24'(`RSC_LVR_DELAY_CYC),
    parameter logic [15:0] LVR_QUAL_CYC  = 16'(`RSC_LVR_QUAL_CYC)
)
(
    // Clock and power-on reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Pins and analog sources
    input  wire logic        external_nrst_pin,
    input  wire logic        slow_internal_osc,
    input  wire logic        supply_low,
    // Watchdog and mode inputs
    input  wire logic        wdt_timeout,
    input  wire logic        wdt_cfg_fault,
    input  wire logic        low_power_mode,
    input  wire logic [1:0]  pin_share_sel,
    // Register port
    input  wire logic [2:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // Reset outputs to the core
    output logic             core_reset,
    output logic             pc_sp_clear,
    output rsc_init_type     init_ctl,
    output rsc_func_type     pin_func,
    output logic             irq
);

    ////////////////////////////////////////////////////////////////////////
    // State and decoded terms

    rsc_state_vec_type s_q;      // All registered state
    rsc_state_vec_type s_d;      // Next state
    logic              tick;     // Slow oscillator rising edge
    logic              pin_rst;  // Pin configured as reset input
    logic              pin_low;  // Enabled reset pin held low
    logic              sel_bad;  // Select holds no valid code
    logic              lvr_en;   // Brown-out monitor armed
    logic              lvr_hit;  // Qualified low supply
    logic [23:0]       delay_lim; // Start-up length for this cause
    logic              wr_hit;   // Write strobe, decoded by address below
    logic              rd_evt;   // Read of event status

    ////////////////////////////////////////////////////////////////////////
    // Combinational decodes

    // Edge of synchronised slow clock; third stage only for edge
    assign tick    = s_q.slow_internal_osc_s2 & ~s_q.slow_internal_osc_s3;
    // Pin function straight from the select code
    assign pin_rst = (s_q.pin_sel == `RSC_SEL_RESET);
    assign pin_low = pin_rst & ~s_q.nrst_s2;
    // Anything but the two codes is a fault
    assign sel_bad = (s_q.pin_sel != `RSC_SEL_GPIO) &&
                     (s_q.pin_sel != `RSC_SEL_RESET);
    // Monitor is off in sleep and idle
    assign lvr_en  = ~low_power_mode;
    assign lvr_hit = (s_q.qual == LVR_QUAL_CYC);
    // Brown-out and power-on share the longer start-up
    assign delay_lim = (s_q.cause == CAUSE_LVR) ? LVR_DELAY_CYC
                                                : EXT_DELAY_CYC;
    assign wr_hit = reg_wr;
    assign rd_evt = reg_rd && (reg_addr == `RSC_ADDR_EVT);

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic

    always_comb
    begin
        s_d = s_q;

        // Synchronisers; first stages feed only second stages
        s_d.slow_internal_osc_s1 = slow_internal_osc;
        s_d.slow_internal_osc_s2 = s_q.slow_internal_osc_s1;
        s_d.slow_internal_osc_s3 = s_q.slow_internal_osc_s2;
        s_d.nrst_s1 = external_nrst_pin;
        s_d.nrst_s2 = s_q.nrst_s1;
        s_d.low_s1  = supply_low;
        s_d.low_s2  = s_q.low_s1;

        // Defaults for pulse outputs
        s_d.warm  = 1'b0;
        s_d.rdata = 8'h00;

        // Low supply must persist; short dips restart the count
        if (lvr_en && s_q.low_s2)
        begin
            if (!lvr_hit)
            begin
                s_d.qual = s_q.qual + 16'h0001;
            end
        end
        else
        begin
            s_d.qual = 16'h0000;
        end

        // Register reads; one cycle later on the port
        if (reg_rd)
        begin
            case (reg_addr)
                `RSC_ADDR_PINSEL:
                begin
                    s_d.rdata = s_q.pin_sel;
                end
                `RSC_ADDR_FLAGS:
                begin
                    // Unused bits stay zero
                    s_d.rdata[`RSC_FB_KEEP]  = s_q.keep;
                    s_d.rdata[`RSC_FB_FAULT] = s_q.fault;
                    s_d.rdata[`RSC_FB_BROWN] = s_q.brown;
                    s_d.rdata[`RSC_FB_WCFG]  = s_q.wcfg;
                end
                `RSC_ADDR_STAT:
                begin
                    s_d.rdata[`RSC_SB_EXPIRY] = s_q.expiry;
                    s_d.rdata[`RSC_SB_PDOWN]  = s_q.pdown;
                end
                `RSC_ADDR_EVT:
                begin
                    s_d.rdata = {4'h0, s_q.evt};
                end
                `RSC_ADDR_MASK:
                begin
                    s_d.rdata = {4'h0, s_q.mask};
                end
                default:
                begin
                    // Unmapped reads return zero
                    s_d.rdata = 8'h00;
                end
            endcase
        end

        // Reading event status clears it; later sets win
        if (rd_evt)
        begin
            s_d.evt = 4'h0;
        end

        // Register writes
        if (wr_hit)
        begin
            case (reg_addr)
                `RSC_ADDR_PINSEL:
                begin
                    s_d.pin_sel = reg_wdata;
                end
                `RSC_ADDR_FLAGS:
                begin
                    s_d.keep  = reg_wdata[`RSC_FB_KEEP];
                    // Flags clear on a zero, a one is ignored
                    s_d.fault = s_q.fault & reg_wdata[`RSC_FB_FAULT];
                    s_d.brown = s_q.brown & reg_wdata[`RSC_FB_BROWN];
                    s_d.wcfg  = s_q.wcfg & reg_wdata[`RSC_FB_WCFG];
                end
                `RSC_ADDR_MASK:
                begin
                    s_d.mask = reg_wdata[3:0];
                end
                default:
                begin
                    // Read-only and unmapped writes are dropped
                    s_d.mask = s_d.mask;
                end
            endcase
        end

        // Sequencer
        case (s_q.st)
            ST_RUN:
            begin
                s_d.ticks = 2'h0;
                if (pin_low)
                begin
                    // Pin reset acts at once, no debounce
                    s_d.st    = ST_HOLD;
                    s_d.cause = CAUSE_EXT;
                    s_d.evt[`RSC_EV_EXT] = 1'b1;
                end
                else if (wdt_timeout && low_power_mode)
                begin
                    // Warm reset: only program counter and stack
                    s_d.warm   = 1'b1;
                    s_d.expiry = 1'b1;
                    s_d.pdown  = 1'b1;
                    s_d.evt[`RSC_EV_WDT] = 1'b1;
                end
                else if (wdt_timeout)
                begin
                    // Full reset, power-down flag untouched
                    s_d.st     = ST_HOLD;
                    s_d.cause  = CAUSE_WDT;
                    s_d.expiry = 1'b1;
                    s_d.evt[`RSC_EV_WDT] = 1'b1;
                end
                else if (lvr_hit)
                begin
                    s_d.st    = ST_DEB;
                    s_d.cause = CAUSE_LVR;
                end
                else if (sel_bad)
                begin
                    s_d.st    = ST_DEB;
                    s_d.cause = CAUSE_PINCFG;
                end
                else if (wdt_cfg_fault)
                begin
                    s_d.st    = ST_DEB;
                    s_d.cause = CAUSE_WDTCFG;
                end
            end
            ST_DEB:
            begin
                // Count slow edges; the third lands 2 to 3 cycles in
                if (tick)
                begin
                    s_d.ticks = s_q.ticks + 2'h1;
                end
                if (pin_low)
                begin
                    // Pin reset overrides a pending debounce
                    s_d.st    = ST_HOLD;
                    s_d.cause = CAUSE_EXT;
                    s_d.evt[`RSC_EV_EXT] = 1'b1;
                end
                else if (s_q.ticks == `RSC_DEB_TICKS)
                begin
                    s_d.st = ST_HOLD;
                    case (s_q.cause)
                        CAUSE_LVR:
                        begin
                            s_d.brown = 1'b1;
                            s_d.evt[`RSC_EV_BROWN] = 1'b1;
                        end
                        CAUSE_PINCFG:
                        begin
                            s_d.fault = 1'b1;
                            s_d.evt[`RSC_EV_FAULT] = 1'b1;
                        end
                        default:
                        begin
                            s_d.wcfg = 1'b1;
                        end
                    endcase
                end
            end
            ST_HOLD:
            begin
                // Stay while a pin or brown-out cause is still present
                if (!((s_q.cause == CAUSE_EXT && pin_low) ||
                      (s_q.cause == CAUSE_LVR && s_q.low_s2)))
                begin
                    s_d.st  = ST_STARTUP;
                    s_d.cnt = 24'h000000;
                    // Non-warm resets restore the select code
                    s_d.pin_sel = `RSC_SEL_GPIO;
                end
            end
            ST_STARTUP:
            begin
                s_d.cnt = s_q.cnt + 24'h000001;
                if (lvr_hit)
                begin
                    // A fresh brown-out restarts the sequence
                    s_d.st    = ST_HOLD;
                    s_d.cause = CAUSE_LVR;
                    s_d.brown = 1'b1;
                    s_d.evt[`RSC_EV_BROWN] = 1'b1;
                end
                else if (s_q.cnt >= delay_lim)
                begin
                    s_d.st = ST_RUN;
                end
            end
            default:
            begin
                s_d.st = ST_HOLD;
            end
        endcase

        // Reset level and start-up conditions follow the state
        s_d.core_rst = (s_d.st == ST_HOLD) || (s_d.st == ST_STARTUP);
        s_d.init.irq_off   = s_d.core_rst;
        s_d.init.wdt_clear = s_d.core_rst;
        s_d.init.timer_off = s_d.core_rst;
        s_d.init.io_input  = s_d.core_rst;
        s_d.init.sp_top    = s_d.core_rst;

        // Select code wins over the general sharing choice
        s_d.func.reset_mode = (s_d.pin_sel == `RSC_SEL_RESET);
        s_d.func.share = s_d.func.reset_mode ? 2'h0 : pin_share_sel;

        // Level interrupt from unmasked sticky events
        s_d.irq = |(s_d.evt & s_d.mask);
    end

    ////////////////////////////////////////////////////////////////////////
    // State register; power-on clears every flag

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            // Power-on starts in the long start-up
            s_q          <= '0;
            s_q.st       <= ST_STARTUP;
            s_q.cause    <= CAUSE_LVR;
            s_q.pin_sel  <= `RSC_SEL_GPIO;
            s_q.core_rst <= 1'b1;
            s_q.init     <= '1;
            s_q.slow_internal_osc_s1  <= 1'b0;
            s_q.nrst_s1  <= 1'b1;
            s_q.nrst_s2  <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, each straight from the state register

    assign reg_rdata   = s_q.rdata;
    assign core_reset  = s_q.core_rst;
    assign pc_sp_clear = s_q.warm;
    assign init_ctl    = s_q.init;
    assign pin_func    = s_q.func;
    assign irq         = s_q.irq;

endmodule // rsc_top

`default_nettype wire

// file: logic/rsc_cfg.svh
// Constants of the reset source controller
//
// Operation
// - Code 55h makes pin general port bit
// - Code aah makes pin active-low reset
// - Other codes reset after 2-3 slow ticks
// - Non-warm resets restore select to 55h
// - Select code overrides general pin sharing
// - Enabled low pin resets, restarts from zero
// - Start-up delay follows pin reset release
// - Brown-out active in run, off in sleep
// - Only qualified low supply causes reset
// - Qualified brown-out resets, sets brownout flag
// - Pin fault flag: set by fault, cleared
// - Software may clear, never set, brownout
// - Flag bits 6-4 and 1 read zero
// - Run-mode watchdog expiry resets, sets expiry
// - Sleep watchdog expiry: warm clear, two flags
// - Power-on clears flags, brown-out keeps them
// - Reset leaves interrupts off, ports inputs, etc
`ifndef RSC_CFG_SVH
`define RSC_CFG_SVH
`define RSC_SEL_GPIO     8'h55
`define RSC_SEL_RESET    8'haa
`define RSC_ADDR_PINSEL  3'h0
`define RSC_ADDR_FLAGS   3'h1
`define RSC_ADDR_STAT    3'h2
`define RSC_ADDR_EVT     3'h3
`define RSC_ADDR_MASK    3'h4
`define RSC_FB_KEEP      7
`define RSC_FB_FAULT     3
`define RSC_FB_BROWN     2
`define RSC_FB_WCFG      0
`define RSC_SB_EXPIRY    1
`define RSC_SB_PDOWN     0
`define RSC_EV_FAULT     0
`define RSC_EV_BROWN     1
`define RSC_EV_WDT       2
`define RSC_EV_EXT       3
`define RSC_DEB_TICKS    2'h3
`define RSC_CLK_NS       10
`define RSC_EXT_DELAY_NS 16700000
`define RSC_LVR_DELAY_NS 50000000
`define RSC_LVR_QUAL_NS  100000
`define RSC_EXT_DELAY_CYC (`RSC_EXT_DELAY_NS / `RSC_CLK_NS)
`define RSC_LVR_DELAY_CYC (`RSC_LVR_DELAY_NS / `RSC_CLK_NS)
`define RSC_LVR_QUAL_CYC  ((`RSC_LVR_QUAL_NS + `RSC_CLK_NS - 1) / `RSC_CLK_NS)
`endif

// file: logic/rsc_pkg.sv
// Types of the reset source controller
package rsc_pkg;
    typedef enum logic [1:0] {
        ST_RUN     = 2'b00,
        ST_DEB     = 2'b01,
        ST_HOLD    = 2'b10,
        ST_STARTUP = 2'b11
    } rsc_state_type;
    typedef enum logic [2:0] {
        CAUSE_EXT    = 3'b000,
        CAUSE_LVR    = 3'b001,
        CAUSE_PINCFG = 3'b010,
        CAUSE_WDTCFG = 3'b011,
        CAUSE_WDT    = 3'b100
    } rsc_cause_type;
    typedef struct packed {
        logic irq_off;
        logic wdt_clear;
        logic timer_off;
        logic io_input;
        logic sp_top;
    } rsc_init_type;
    typedef struct packed {
        logic       reset_mode;
        logic [1:0] share;
    } rsc_func_type;
    typedef struct packed {
        rsc_state_type st;
        rsc_cause_type cause;
        logic [23:0]   cnt;
        logic [15:0]   qual;
        logic [1:0]    ticks;
        logic [7:0]    pin_sel;
        logic          fault;
        logic          brown;
        logic          wcfg;
        logic          keep;
        logic          expiry;
        logic          pdown;
        logic [3:0]    evt;
        logic [3:0]    mask;
        logic [7:0]    rdata;
        logic          core_rst;
        logic          warm;
        rsc_init_type  init;
        rsc_func_type  func;
        logic          irq;
        logic          slow_internal_osc_s1;
        logic          slow_internal_osc_s2;
        logic          slow_internal_osc_s3;
        logic          nrst_s1;
        logic          nrst_s2;
        logic          low_s1;
        logic          low_s2;
    } rsc_state_vec_type;
endpackage

// file: tb/rsc_top_chk.sv
// Port-level assertion checker for the reset source controller
`timescale 1ns/1ps
`default_nettype none
`include "rsc_cfg.svh"

module rsc_top_chk
    import rsc_pkg::*;
#(
    parameter logic [23:0] EXT_DELAY_CYC = 24'h14
)
(
    // Clock and reset
    input wire logic         clk,
    input wire logic         rst,
    // Sources and modes
    input wire logic         external_nrst_pin,
    input wire logic         wdt_timeout,
    input wire logic         low_power_mode,
    input wire logic [1:0]   pin_share_sel,
    // Register port
    input wire logic [2:0]   reg_addr,
    input wire logic         reg_rd,
    input wire logic [7:0]   reg_rdata,
    // Reset outputs
    input wire logic         core_reset,
    input wire logic         pc_sp_clear,
    input wire rsc_init_type init_ctl,
    input wire rsc_func_type pin_func
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////
    logic [23:0] hold_q; // Cycles core_reset has stood high
    logic [23:0] hold_d; // Saturates so a long hold never wraps to zero

    // Count the length of each internal reset
    always_comb
    begin
        hold_d = core_reset ? ((&hold_q) ? hold_q : hold_q + 24'h1) : 24'h0;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            hold_q <= 24'h0;
        else
            hold_q <= hold_d;
    end

    ////////////////////////////////////////////////////////////////////////
    sequence s_warm_cause;
        wdt_timeout && low_power_mode && !core_reset;
    endsequence
    sequence s_flags_rd;
        reg_rd && reg_addr == `RSC_ADDR_FLAGS;
    endsequence

    property p_init;
        init_ctl == {5{core_reset}};
    endproperty
    property p_share_zero;
        pin_func.reset_mode |-> pin_func.share == 2'h0;
    endproperty
    property p_share_follow;
        (!pin_func.reset_mode && !$past(rst)) |-> pin_func.share == $past(pin_share_sel);
    endproperty
    property p_pin_reset;
        ($fell(external_nrst_pin) && pin_func.reset_mode && !core_reset) |-> ##[1:6] core_reset;
    endproperty
    property p_hold;
        $fell(core_reset) |-> hold_q >= EXT_DELAY_CYC;
    endproperty
    property p_warm;
        s_warm_cause |=> (pc_sp_clear && !core_reset) ##1 !pc_sp_clear;
    endproperty
    property p_wdt_run;
        (wdt_timeout && !low_power_mode && !core_reset) |-> ##[1:3] core_reset;
    endproperty
    property p_flags_zero;
        s_flags_rd |=> reg_rdata[6:4] == 3'h0 && reg_rdata[1] == 1'b0;
    endproperty
    property p_rdata_idle;
        !$past(reg_rd) |-> reg_rdata == 8'h00;
    endproperty

    a_init: assert property (p_init) else $error("init controls differ from reset");
    a_share_zero: assert property (p_share_zero) else $error("sharing not forced");
    a_share_follow: assert property (p_share_follow) else $error("sharing lost");
    a_pin_reset: assert property (p_pin_reset) else $error("pin low ignored");
    a_hold: assert property (p_hold) else $error("reset released too early");
    a_warm: assert property (p_warm) else $error("warm clear wrong");
    a_wdt_run: assert property (p_wdt_run) else $error("expiry did not reset");
    a_flags_zero: assert property (p_flags_zero) else $error("flag holes not zero");
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");
endmodule // rsc_top_chk

bind rsc_top rsc_top_chk #(.EXT_DELAY_CYC(EXT_DELAY_CYC)) u_chk
(
    .clk(clk), .rst(rst), .external_nrst_pin(external_nrst_pin),
    .wdt_timeout(wdt_timeout), .low_power_mode(low_power_mode),
    .pin_share_sel(pin_share_sel), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .core_reset(core_reset), .pc_sp_clear(pc_sp_clear),
    .init_ctl(init_ctl), .pin_func(pin_func)
);
`default_nettype wire

// file: tb/rsc_partner.sv
// Model of the reset network, supply monitor and slow oscillator
`timescale 1ns/1ps
`default_nettype none

module rsc_partner
(
    // Clock and requests from the bench
    input wire logic  clk,
    input wire logic  pin_low_req,
    input wire logic  supply_low_req,
    // Lines into the block
    output logic      external_nrst_pin,
    output var logic  slow_internal_osc,
    output logic      supply_low
);
    logic [1:0] div_q = 2'h0; // Oscillator divider

    // Pull-up network keeps the pin high unless pulled down
    assign external_nrst_pin = !pin_low_req;
    assign supply_low        = supply_low_req;

    // Slow oscillator runs free, eight fast cycles a period
    initial slow_internal_osc = 1'b0;
    always @(posedge clk)
    begin
        div_q <= div_q + 2'h1;
        if (div_q == 2'h3)
            slow_internal_osc <= !slow_internal_osc;
    end
endmodule // rsc_partner
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench of the reset source controller
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import rsc_pkg::*;
    localparam int EXT = 20; // Shortened start-up delay

    logic         clk = 1'b0;      // Fast clock
    logic         rst = 1'b1;      // Power-on reset
    logic         pin_low = 1'b0;  // Pull the reset pin down
    logic         sup_low = 1'b0;  // Supply below threshold
    logic         wdt_to = 1'b0;   // Watchdog expiry pulse
    logic         wdt_cfg = 1'b0;  // Watchdog code fault
    logic         lpm = 1'b0;      // Sleep or idle
    logic [1:0]   share = 2'h2;    // General pin sharing choice
    logic [2:0]   reg_addr = 3'h0;
    logic [7:0]   reg_wdata = 8'h00;
    logic         reg_wr = 1'b0;
    logic         reg_rd = 1'b0;
    logic [7:0]   reg_rdata;
    logic         core_reset;
    logic         pc_sp_clear;
    logic         irq;
    logic         nrst_w;
    logic         osc_w;
    logic         low_w;
    rsc_init_type init_ctl;
    rsc_func_type pin_func;
    int           fail_count = 0;
    int           n_checks = 0;
    int           n;

    always #5 clk = !clk;

    rsc_partner u_part (.clk(clk), .pin_low_req(pin_low), .supply_low_req(sup_low),
        .external_nrst_pin(nrst_w), .slow_internal_osc(osc_w), .supply_low(low_w));

    rsc_top #(.EXT_DELAY_CYC(24'd20), .LVR_DELAY_CYC(24'd30), .LVR_QUAL_CYC(16'd5)) uut (
        .clk(clk), .rst(rst), .external_nrst_pin(nrst_w), .slow_internal_osc(osc_w),
        .supply_low(low_w), .wdt_timeout(wdt_to), .wdt_cfg_fault(wdt_cfg),
        .low_power_mode(lpm), .pin_share_sel(share), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .core_reset(core_reset), .pc_sp_clear(pc_sp_clear), .init_ctl(init_ctl),
        .pin_func(pin_func), .irq(irq));

    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Compare one value of up to eight bits
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the read edge
    task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask

    // Bounded wait for the internal reset to reach a level
    task automatic wait_cr(input logic lvl, input int lim);
        n = 0;
        while (core_reset !== lvl && n < lim)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        if (core_reset !== lvl)
        begin
            chk({7'h0, core_reset}, {7'h0, lvl});
            stop_test();
        end
    endtask

    // One-cycle watchdog pulse: code fault when cfg, else expiry
    task automatic pulse_wdt(input logic cfg);
        @(posedge clk);
        if (cfg)
            wdt_cfg <= 1'b1;
        else
            wdt_to <= 1'b1;
        @(posedge clk);
        wdt_cfg <= 1'b0;
        wdt_to  <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        wait_cr(1'b0, 100);
        rd_chk(3'h0, 8'h55);
        rd_chk(3'h1, 8'h00);
        rd_chk(3'h2, 8'h00);
        rd_chk(3'h7, 8'h00);
        rd_chk(3'h3, 8'h00);
        chk({5'h0, pin_func}, 8'h02);
        chk({3'h0, init_ctl}, 8'h00);
        @(posedge clk);
        share <= 2'h1;
        repeat (2) @(posedge clk);
        #1;
        chk({5'h0, pin_func}, 8'h01);
        $display("test reset done");
    endtask

    task automatic t_pin();
        wr(3'h0, 8'haa);
        rd_chk(3'h0, 8'haa);
        chk({5'h0, pin_func}, 8'h04);
        pin_low <= 1'b1;
        wait_cr(1'b1, 20);
        repeat (8) @(posedge clk);
        chk({7'h0, core_reset}, 8'h01);
        chk({3'h0, init_ctl}, 8'h1f);
        pin_low <= 1'b0;
        wait_cr(1'b0, 100);
        chk({7'h0, n >= EXT && n <= EXT + 8}, 8'h01);
        rd_chk(3'h0, 8'h55);
        rd_chk(3'h3, 8'h08);
        $display("test pin done");
    endtask

    task automatic t_faults();
        wr(3'h0, 8'h12);
        wait_cr(1'b1, 200);
        wait_cr(1'b0, 200);
        rd_chk(3'h1, 8'h08);
        rd_chk(3'h0, 8'h55);
        wr(3'h1, 8'h00);
        rd_chk(3'h1, 8'h00);
        pulse_wdt(1'b1);
        wait_cr(1'b1, 200);
        wait_cr(1'b0, 200);
        rd_chk(3'h1, 8'h01);
        wr(3'h1, 8'hfe);
        rd_chk(3'h1, 8'h80);
        wr(3'h1, 8'h00);
        $display("test faults done");
    endtask

    task automatic t_wdt_run();
        pulse_wdt(1'b0);
        wait_cr(1'b1, 10);
        wait_cr(1'b0, 100);
        rd_chk(3'h2, 8'h02);
        $display("test watchdog run done");
    endtask

    task automatic t_brown();
        sup_low <= 1'b1;
        repeat (3) @(posedge clk);
        sup_low <= 1'b0;
        repeat (60) @(posedge clk);
        chk({7'h0, core_reset}, 8'h00);
        lpm     <= 1'b1;
        sup_low <= 1'b1;
        repeat (60) @(posedge clk);
        chk({7'h0, core_reset}, 8'h00);
        sup_low <= 1'b0;
        repeat (4) @(posedge clk);
        lpm     <= 1'b0;
        sup_low <= 1'b1;
        wait_cr(1'b1, 200);
        sup_low <= 1'b0;
        wait_cr(1'b0, 200);
        rd_chk(3'h1, 8'h04);
        rd_chk(3'h2, 8'h02);
        wr(3'h1, 8'h00);
        rd_chk(3'h1, 8'h00);
        $display("test brown-out done");
    endtask

    task automatic t_wdt_sleep();
        wr(3'h0, 8'haa);
        wr(3'h4, 8'h04);
        rd_chk(3'h3, 8'h07);
        chk({7'h0, irq}, 8'h00);
        lpm <= 1'b1;
        pulse_wdt(1'b0);
        #1;
        chk({7'h0, pc_sp_clear}, 8'h01);
        repeat (3) @(posedge clk);
        chk({7'h0, core_reset}, 8'h00);
        chk({7'h0, irq}, 8'h01);
        rd_chk(3'h2, 8'h03);
        rd_chk(3'h0, 8'haa);
        rd_chk(3'h3, 8'h04);
        repeat (2) @(posedge clk);
        chk({7'h0, irq}, 8'h00);
        lpm <= 1'b0;
        wr(3'h0, 8'h55);
        $display("test watchdog sleep done");
    endtask

    task automatic t_por();
        wr(3'h0, 8'h33);
        wait_cr(1'b1, 200);
        wait_cr(1'b0, 200);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        wait_cr(1'b0, 100);
        rd_chk(3'h2, 8'h00);
        rd_chk(3'h1, 8'h00);
        $display("test power-on done");
    endtask

    initial
    begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_pin();
        t_faults();
        t_wdt_run();
        t_brown();
        t_wdt_sleep();
        t_por();
        stop_test();
    end
endmodule // tb_top
`default_nettype wire
